// *** hw/tccu_top.sv ***
`timescale 1ns/100ps
`include "tccu_defines.svh"

// Operation
// - capture copies whole counter value at once
// - capture pins synchronised before latching count
// - edge select 00 off,01 rise,10 fall,11 any
// - edge select bits clear at reset
// - captures independent, same cycle same value
// - capture registers untouched by reset
// - high byte read blocks capture two cycles
// - blocked capture held, written in the cycle after the block
// - function bit 1 capture, 0 compare default
// - driven bit3 pin edges still capture
// - writes to shared register ignored in capture
// - comparators check counter every cycle except the one after a high byte write; fifth only in compare mode
// - match sets flag, mask gates interrupt
// - compare registers reset to all ones
// - pin action every match regardless of flag
// - channel one drives any masked pin combination
// - high byte write suppresses compare one cycle
// - compare registers fully readable and writable
// - pin change lags match flag by one cycle
// - mode/level 00 off,01 toggle,10 low,11 high
// - channel one copies data bits 7..3 to pins 4..0
// - flags clear only on written ones
// - counter from zero, wraps, not writable
module tccu_top (
    input  wire logic                   CLK_I,
    input  wire logic                   RST_N_I,
    input  wire tccu_pkg::tccu_apb_req_t APB_REQ_I,
    output tccu_pkg::tccu_apb_rsp_t      APB_RSP_O,
    input  wire logic [3:0]             CAP_PIN_I,
    output logic [4:0]                  CMP_PIN_O,
    output logic [4:0]                  CMP_PIN_OE_N_O,
    output logic [15:0]                 COUNT_O,
    output logic [7:0]                  FLAG_O,
    output logic                        IRQ_O
);
    import tccu_pkg::*;

    tccu_state_t r;
    tccu_state_t next_r;

    logic        shared_cap;
    logic        wr_take;
    logic        rd_take;
    logic [11:0] addr;
    logic [3:0]  cap_hi_read;
    logic [4:0]  cmp_hi_write;
    logic [4:0]  match;
    logic [3:0]  edge_hit;
    logic [3:0]  pin_lvl;
    logic [4:0]  cmp_pin_used;
    logic        mapped;

    assign shared_cap = r.acc_ctl[`TCCU_ACC_FUNC_BIT];
    assign addr       = APB_REQ_I.paddr;
    assign wr_take    = (r.bus == TCCU_BUS_ACCESS) && APB_REQ_I.pwrite;
    assign rd_take    = (r.bus == TCCU_BUS_ACCESS) && !APB_REQ_I.pwrite;

    // the high byte of a 16-bit pair is byte lane 1; a word read touches it too
    assign cap_hi_read[0] = rd_take && addr == `TCCU_ADDR_CAP1;
    assign cap_hi_read[1] = rd_take && addr == `TCCU_ADDR_CAP2;
    assign cap_hi_read[2] = rd_take && addr == `TCCU_ADDR_CAP3;
    assign cap_hi_read[3] = rd_take && addr == `TCCU_ADDR_SHARED && shared_cap;

    assign cmp_hi_write[0] = wr_take && APB_REQ_I.pstrb[1] && addr == `TCCU_ADDR_CMP1;
    assign cmp_hi_write[1] = wr_take && APB_REQ_I.pstrb[1] && addr == `TCCU_ADDR_CMP2;
    assign cmp_hi_write[2] = wr_take && APB_REQ_I.pstrb[1] && addr == `TCCU_ADDR_CMP3;
    assign cmp_hi_write[3] = wr_take && APB_REQ_I.pstrb[1] && addr == `TCCU_ADDR_CMP4;
    assign cmp_hi_write[4] = wr_take && APB_REQ_I.pstrb[1] && addr == `TCCU_ADDR_SHARED && !shared_cap;

    // bit3 pin as seen by capture: our own drive when the direction bit makes it an output
    always_comb begin
        pin_lvl = CAP_PIN_I;
        if (r.acc_ctl[`TCCU_ACC_DIR3_BIT]) begin
            pin_lvl[3] = r.port_out[0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_edge
            logic rise;
            logic fall;
            logic en;
            assign rise = r.pin_s1[gi] && !r.pin_prev[gi];
            assign fall = !r.pin_s1[gi] && r.pin_prev[gi];
            assign en   = (gi < 3) || shared_cap;
            assign edge_hit[gi] = en && ((r.edge_sel[2*gi] && rise) || (r.edge_sel[2*gi+1] && fall));
        end
        for (gi = 0; gi < 5; gi++) begin : g_cmp
            // comparator skipped one cycle after a high byte write; the shared one only in compare mode
            assign match[gi] = (r.cmp[gi] == r.count) && !r.cmp_inhibit[gi] &&
                               ((gi < 4) || !shared_cap);
        end
    endgenerate

    always_comb begin
        logic [15:0] wv;
        logic [7:0]  clr;
        logic [4:0]  p;
        wv       = 16'h0000;
        clr      = 8'h00;
        p        = r.port_out;
        next_r   = r;
        mapped   = 1'b1;

        next_r.count = r.count + 16'h0001;

        // double-flop synchroniser, prev only reads the second stage
        next_r.pin_s0   = pin_lvl;
        next_r.pin_s1   = r.pin_s0;
        next_r.pin_prev = r.pin_s1;

        next_r.cap_block = cap_hi_read;
        for (int i = 0; i < 4; i++) begin
            if (edge_hit[i] || r.cap_pend[i]) begin
                if (r.cap_block[i] || cap_hi_read[i]) begin
                    // deferred, not dropped; keeps the count of the edge
                    next_r.cap_pend[i]     = 1'b1;
                    if (edge_hit[i] && !r.cap_pend[i]) begin
                        next_r.cap_pend_val[i] = r.count;
                    end
                end else begin
                    next_r.cap[i]      = r.cap_pend[i] ? r.cap_pend_val[i] : r.count;
                    next_r.cap_pend[i] = 1'b0;
                end
            end
        end

        next_r.cmp_inhibit = cmp_hi_write;
        next_r.match_d     = match;

        // pin actions one cycle after the match; channel one first, others override their own pin
        for (int b = 0; b < 5; b++) begin
            if (r.match_d[0] && r.pin_mask[3+b]) begin
                p[b] = r.pin_data[3+b];
            end
        end
        for (int c = 1; c < 5; c++) begin
            if (r.match_d[c]) begin
                case (tccu_action_t'({r.action[2*(4-c)+1], r.action[2*(4-c)]}))
                    TCCU_ACT_TOGGLE: p[4-c] = !r.port_out[4-c];
                    TCCU_ACT_LOW:    p[4-c] = 1'b0;
                    TCCU_ACT_HIGH:   p[4-c] = 1'b1;
                    default:         p[4-c] = p[4-c];
                endcase
            end
        end
        next_r.port_out = p;

        // bus decode
        wv = APB_REQ_I.pwdata[15:0];
        case (addr)
            `TCCU_ADDR_EDGE_SEL, `TCCU_ADDR_CAP1, `TCCU_ADDR_CAP2, `TCCU_ADDR_CAP3,
            `TCCU_ADDR_SHARED, `TCCU_ADDR_CMP1, `TCCU_ADDR_CMP2, `TCCU_ADDR_CMP3,
            `TCCU_ADDR_CMP4, `TCCU_ADDR_PIN_MASK, `TCCU_ADDR_PIN_DATA, `TCCU_ADDR_ACTION,
            `TCCU_ADDR_FLAG, `TCCU_ADDR_MASK, `TCCU_ADDR_ACCUM_CTL, `TCCU_ADDR_COUNT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase

        if (wr_take && APB_REQ_I.pstrb[0]) begin
            case (addr)
                `TCCU_ADDR_EDGE_SEL:  next_r.edge_sel = wv[7:0];
                `TCCU_ADDR_PIN_MASK:  next_r.pin_mask = {wv[7:3], 3'b000};
                `TCCU_ADDR_PIN_DATA:  next_r.pin_data = {wv[7:3], 3'b000};
                `TCCU_ADDR_ACTION:    next_r.action   = wv[7:0];
                `TCCU_ADDR_FLAG:      clr             = wv[7:0];
                `TCCU_ADDR_MASK:      next_r.mask     = wv[7:0];
                `TCCU_ADDR_ACCUM_CTL: next_r.acc_ctl  = wv[7:0];
                default:              clr             = 8'h00;
            endcase
        end
        for (int k = 0; k < 5; k++) begin
            logic [11:0] a;
            a = (k == 4) ? `TCCU_ADDR_SHARED : 12'(`TCCU_ADDR_CMP1 + 12'(4 * k));
            if (wr_take && addr == a && !(k == 4 && shared_cap)) begin
                if (APB_REQ_I.pstrb[1]) begin
                    next_r.cmp[k][15:8] = wv[15:8];
                end
                if (APB_REQ_I.pstrb[0]) begin
                    next_r.cmp[k][7:0] = wv[7:0];
                end
            end
        end

        // set wins over a same-cycle clear
        next_r.flag = (r.flag & ~clr) |
                      {match[0], match[1], match[2], match[3],
                       match[4] | edge_hit[3], edge_hit[0], edge_hit[1], edge_hit[2]};

        next_r.prdata  = 32'h0000_0000;
        next_r.pslverr = 1'b0;
        case (r.bus)
            TCCU_BUS_IDLE: begin
                if (APB_REQ_I.psel && !APB_REQ_I.penable) begin
                    next_r.bus = TCCU_BUS_ACCESS;
                end
            end
            TCCU_BUS_ACCESS: begin
                next_r.bus     = TCCU_BUS_DONE;
                next_r.pslverr = !mapped;
                if (!APB_REQ_I.pwrite) begin
                    case (addr)
                        `TCCU_ADDR_EDGE_SEL:  next_r.prdata[7:0]  = r.edge_sel;
                        `TCCU_ADDR_CAP1:      next_r.prdata[15:0] = r.cap[0];
                        `TCCU_ADDR_CAP2:      next_r.prdata[15:0] = r.cap[1];
                        `TCCU_ADDR_CAP3:      next_r.prdata[15:0] = r.cap[2];
                        `TCCU_ADDR_SHARED:    next_r.prdata[15:0] = shared_cap ? r.cap[3] : r.cmp[4];
                        `TCCU_ADDR_CMP1:      next_r.prdata[15:0] = r.cmp[0];
                        `TCCU_ADDR_CMP2:      next_r.prdata[15:0] = r.cmp[1];
                        `TCCU_ADDR_CMP3:      next_r.prdata[15:0] = r.cmp[2];
                        `TCCU_ADDR_CMP4:      next_r.prdata[15:0] = r.cmp[3];
                        `TCCU_ADDR_PIN_MASK:  next_r.prdata[7:0]  = r.pin_mask;
                        `TCCU_ADDR_PIN_DATA:  next_r.prdata[7:0]  = r.pin_data;
                        `TCCU_ADDR_ACTION:    next_r.prdata[7:0]  = r.action;
                        `TCCU_ADDR_FLAG:      next_r.prdata[7:0]  = r.flag;
                        `TCCU_ADDR_MASK:      next_r.prdata[7:0]  = r.mask;
                        `TCCU_ADDR_ACCUM_CTL: next_r.prdata[7:0]  = r.acc_ctl;
                        `TCCU_ADDR_COUNT:     next_r.prdata[15:0] = r.count;
                        default:              next_r.prdata       = 32'h0000_0000;
                    endcase
                end
            end
            TCCU_BUS_DONE: begin
                next_r.bus = TCCU_BUS_IDLE;
            end
            default: begin
                next_r.bus = TCCU_BUS_IDLE;
            end
        endcase
    end

    // capture values and their pending copies deliberately keep their contents through reset
    always_ff @(posedge CLK_I) begin
        r <= next_r;
        if (!RST_N_I) begin
            r.bus          <= TCCU_BUS_IDLE;
            r.count        <= `TCCU_COUNT_RESET;
            r.edge_sel     <= 8'h00;
            r.cap_block    <= 4'h0;
            r.cap_pend     <= 4'h0;
            r.pin_s0       <= 4'h0;
            r.pin_s1       <= 4'h0;
            r.pin_prev     <= 4'h0;
            r.cmp          <= {5{`TCCU_CMP_RESET}};
            r.cmp_inhibit  <= 5'h00;
            r.match_d      <= 5'h00;
            r.pin_mask     <= 8'h00;
            r.pin_data     <= 8'h00;
            r.action       <= 8'h00;
            r.flag         <= 8'h00;
            r.mask         <= 8'h00;
            r.acc_ctl      <= 8'h00;
            r.port_out     <= `TCCU_PORT_RESET;
            r.prdata       <= 32'h0000_0000;
            r.pslverr      <= 1'b0;
        end
    end

    // pin owned by compare logic when it has an action or channel one mask selects it
    always_comb begin
        for (int c = 0; c < 5; c++) begin
            cmp_pin_used[c] = r.pin_mask[3+c];
        end
        for (int c = 1; c < 4; c++) begin
            cmp_pin_used[4-c] = cmp_pin_used[4-c] | (r.action[2*(4-c)+1] | r.action[2*(4-c)]);
        end
        cmp_pin_used[0] = cmp_pin_used[0] | ((r.action[1] | r.action[0]) & !shared_cap)
                          | r.acc_ctl[`TCCU_ACC_DIR3_BIT];
    end

    assign APB_RSP_O.prdata  = r.prdata;
    assign APB_RSP_O.pready  = (r.bus == TCCU_BUS_DONE);
    assign APB_RSP_O.pslverr = r.pslverr & (r.bus == TCCU_BUS_DONE);
    assign CMP_PIN_O         = r.port_out;
    assign CMP_PIN_OE_N_O    = ~cmp_pin_used;
    assign COUNT_O           = r.count;
    assign FLAG_O            = r.flag;
    assign IRQ_O             = |(r.flag & r.mask);
endmodule

// *** hw/tccu_defines.svh ***
`ifndef TCCU_DEFINES_SVH
`define TCCU_DEFINES_SVH

// register byte addresses on the bus
`define TCCU_ADDR_EDGE_SEL   12'h000
`define TCCU_ADDR_CAP1       12'h004
`define TCCU_ADDR_CAP2       12'h008
`define TCCU_ADDR_CAP3       12'h00c
`define TCCU_ADDR_SHARED     12'h010
`define TCCU_ADDR_CMP1       12'h014
`define TCCU_ADDR_CMP2       12'h018
`define TCCU_ADDR_CMP3       12'h01c
`define TCCU_ADDR_CMP4       12'h020
`define TCCU_ADDR_PIN_MASK   12'h024
`define TCCU_ADDR_PIN_DATA   12'h028
`define TCCU_ADDR_ACTION     12'h02c
`define TCCU_ADDR_FLAG       12'h030
`define TCCU_ADDR_MASK       12'h034
`define TCCU_ADDR_ACCUM_CTL  12'h038
`define TCCU_ADDR_COUNT      12'h03c

// accumulator control fields
`define TCCU_ACC_FUNC_BIT    2
`define TCCU_ACC_DIR3_BIT    3

// flag / mask layout: compare 1..4 at 7..4, shared at 3, capture 1..3 at 2..0
`define TCCU_FLG_CMP1        7
`define TCCU_FLG_SHARED      3

`define TCCU_CMP_RESET       16'hffff
`define TCCU_COUNT_RESET     16'h0000
`define TCCU_PORT_RESET      5'h00

`endif

// *** hw/tccu_pkg.sv ***
package tccu_pkg;
    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } tccu_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } tccu_apb_rsp_t;

    typedef enum logic [1:0] {
        TCCU_ACT_OFF    = 2'b00,
        TCCU_ACT_TOGGLE = 2'b01,
        TCCU_ACT_LOW    = 2'b10,
        TCCU_ACT_HIGH   = 2'b11
    } tccu_action_t;

    typedef enum logic [2:0] {
        TCCU_BUS_IDLE   = 3'b001,
        TCCU_BUS_ACCESS = 3'b010,
        TCCU_BUS_DONE   = 3'b100
    } tccu_bus_state_t;

    typedef struct packed {
        tccu_bus_state_t bus;
        logic [15:0]     count;
        logic [7:0]      edge_sel;
        logic [3:0][15:0] cap;
        logic [3:0]      cap_block;
        logic [3:0]      cap_pend;
        logic [3:0][15:0] cap_pend_val;
        logic [3:0]      pin_s0;
        logic [3:0]      pin_s1;
        logic [3:0]      pin_prev;
        logic [4:0][15:0] cmp;
        logic [4:0]      cmp_inhibit;
        logic [4:0]      match_d;
        logic [7:0]      pin_mask;
        logic [7:0]      pin_data;
        logic [7:0]      action;
        logic [7:0]      flag;
        logic [7:0]      mask;
        logic [7:0]      acc_ctl;
        logic [4:0]      port_out;
        logic [31:0]     prdata;
        logic            pslverr;
    } tccu_state_t;
endpackage

// *** bench/tccu_props.sv ***
`timescale 1ns/100ps
module tccu_props (
    input wire logic                    CLK_I,
    input wire logic                    RST_N_I,
    input wire tccu_pkg::tccu_apb_req_t APB_REQ_I,
    input wire tccu_pkg::tccu_apb_rsp_t APB_RSP_O,
    input wire logic [3:0]              CAP_PIN_I,
    input wire logic [4:0]              CMP_PIN_O,
    input wire logic [4:0]              CMP_PIN_OE_N_O,
    input wire logic [15:0]             COUNT_O,
    input wire logic [7:0]              FLAG_O,
    input wire logic                    IRQ_O
);
    import tccu_pkg::*;
    logic            acc;
    logic [7:0]      wr_ones;
    logic [7:0]      mask_q;
    logic [2:0]      pin_q;
    logic [2:0][7:0] hist;
    assign acc = APB_REQ_I.psel && APB_REQ_I.penable && APB_REQ_I.pwrite && APB_REQ_I.pstrb[0];
    // recent pin changes; eight deep to cover the synchroniser delay before a capture flag
    always_ff @(posedge CLK_I) begin
        pin_q <= CAP_PIN_I[2:0];
        for (int i = 0; i < 3; i++) begin
            hist[i] <= {hist[i][6:0], CAP_PIN_I[i] != pin_q[i]};
        end
        wr_ones <= (acc && APB_REQ_I.paddr == 12'h030) ? APB_REQ_I.pwdata[7:0] : 8'h00;
        if (!RST_N_I) begin
            mask_q <= 8'h00;
        end else if (acc && APB_REQ_I.paddr == 12'h034) begin
            mask_q <= APB_REQ_I.pwdata[7:0];
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence s_fresh;
        $rose(RST_N_I);
    endsequence
    sequence s_matched;
        $past(FLAG_O[6] | FLAG_O[7]);
    endsequence
    property p_cap(int i);
        $rose(FLAG_O[2-i]) |-> hist[i] != 8'h00;
    endproperty
    a_reset_state: assert property (s_fresh |-> COUNT_O == 16'h0000 && FLAG_O == 8'h00 &&
        CMP_PIN_O == 5'h00 && CMP_PIN_OE_N_O == 5'h1f) else $error("state wrong after reset");
    a_count_step: assert property ($past(RST_N_I) |-> COUNT_O == $past(COUNT_O) + 16'h0001)
        else $error("count did not step by one");
    a_irq_mask: assert property (IRQ_O == |(FLAG_O & mask_q))
        else $error("irq not flag and mask");
    a_flag_clear: assert property ((($past(FLAG_O) & ~FLAG_O) & ~wr_ones) == 8'h00)
        else $error("flag dropped without a written one");
    a_cap_one: assert property (p_cap(0)) else $error("capture one flag without edge");
    a_cap_two: assert property (p_cap(1)) else $error("capture two flag without edge");
    a_cap_three: assert property (p_cap(2)) else $error("capture three flag without edge");
    a_pin_lag: assert property ($changed(CMP_PIN_O[3]) |-> s_matched)
        else $error("pin moved without a prior match");
endmodule

bind tccu_top tccu_props props_u (
    .CLK_I          (CLK_I),
    .RST_N_I        (RST_N_I),
    .APB_REQ_I      (APB_REQ_I),
    .APB_RSP_O      (APB_RSP_O),
    .CAP_PIN_I      (CAP_PIN_I),
    .CMP_PIN_O      (CMP_PIN_O),
    .CMP_PIN_OE_N_O (CMP_PIN_OE_N_O),
    .COUNT_O        (COUNT_O),
    .FLAG_O         (FLAG_O),
    .IRQ_O          (IRQ_O)
);

// *** bench/tccu_src.sv ***
`timescale 1ns/100ps
module tccu_src (
    input  wire logic       clk_i,
    input  wire logic [3:0] want_i,
    output logic [3:0]      pin_o
);
    // sources move just after an edge, so the sync stage sees a clean level
    initial pin_o = 4'h0;
    always @(posedge clk_i) pin_o <= want_i;
endmodule

// *** bench/tccu_top_tb.sv ***
`timescale 1ns/100ps
module tccu_top_tb;
    import tccu_pkg::*;
    logic          clk;
    logic          rst_n;
    tccu_apb_req_t req;
    tccu_apb_rsp_t rsp;
    logic [3:0]    want;
    logic [3:0]    cap_pin;
    logic [4:0]    pin;
    logic [4:0]    oe_n;
    logic [15:0]   cnt;
    logic [7:0]    flg;
    logic          irq;
    int            n_fail;
    int            cmp_count;
    int            m_cnt;
    int            seed;
    int            t;
    logic [31:0]   rd;
    logic          err;
    logic          e;
    logic [15:0]   v0;
    logic [7:0]    d;
    logic [7:0]    m;
    logic [3:0]    exp_pin;

    tccu_top dut_u (.CLK_I(clk), .RST_N_I(rst_n), .APB_REQ_I(req), .APB_RSP_O(rsp), .CAP_PIN_I(cap_pin),
        .CMP_PIN_O(pin), .CMP_PIN_OE_N_O(oe_n), .COUNT_O(cnt), .FLAG_O(flg), .IRQ_O(irq));
    tccu_src src_u (.clk_i(clk), .want_i(want), .pin_o(cap_pin));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) m_cnt <= rst_n ? m_cnt + 1 : 0;
    always @(negedge clk) if (rst_n) chk(cnt === m_cnt[15:0], "count");

    task chk(input logic ok, input string s);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("BAD %0t %s", $time, s);
        end
    endtask
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        int k;
        @(posedge clk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: v, pstrb: 4'hf};
        @(posedge clk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 20);
        chk(rsp.pready === 1'b1, "no ready");
        if (rsp.pready !== 1'b1) finish_test;
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask
    task rchk(input logic [11:0] a, input logic [15:0] x, input logic [15:0] k, input string s);
        apb(1'b0, a, 32'h0);
        chk((rd[15:0] & k) === (x & k), s);
    endtask
    task wait_cnt(input int tt);
        for (int k = 0; k < 200 && m_cnt != tt; k++) @(negedge clk);
        chk(m_cnt == tt, "wait ran out");
        if (m_cnt != tt) finish_test;
    endtask

    initial begin
        seed = 32'hd17a;
        n_fail = 0;
        cmp_count = 0;
        m_cnt = 0;
        want = 4'h0;
        exp_pin = 4'h0;
        rst_n = 1'b0;
        req = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 4; a <= 8; a++) begin
            rchk(12'(a * 4), 16'hffff, 16'hffff, "compare reset");
        end
        rchk(12'h000, 16'h0000, 16'h00ff, "edge select reset");
        apb(1'b0, 12'h040, 32'h0);
        chk(err === 1'b1 && rd === 32'h0, "unmapped");
        v0 = 16'($random(seed));
        wr(12'h01c, {16'h0, v0});
        rchk(12'h01c, v0, 16'hffff, "storage");
        wr(12'h038, 32'h4);
        wr(12'h010, 32'h1234);
        wr(12'h038, 32'h0);
        rchk(12'h010, 16'hffff, 16'hffff, "shared write");
        for (int c = 0; c < 4; c++) begin
            wr(12'h000, {24'h0, {4{c[1:0]}}});
            for (int l = 1; l >= 0; l--) begin
                wr(12'h030, 32'hff);
                t = m_cnt;
                want[2:0] <= {3{l[0]}};
                repeat (8) @(posedge clk);
                e = l[0] ? c[0] : c[1];
                rchk(12'h030, {13'h0, {3{e}}}, 16'h0007, "capture flag");
                for (int i = 0; i < 3 && e; i++) begin
                    apb(1'b0, 12'(4 + 4 * i), 32'h0);
                    if (i == 0) v0 = rd[15:0];
                    chk(rd[15:0] === v0 && v0 > t[15:0] && v0 <= t[15:0] + 16'h8, "capture");
                end
            end
        end
        // flags stay set across matches, so every action must still fire
        for (int ch = 0; ch < 4; ch++) begin
            wr(12'h030, 32'hff);
            wr(12'h034, 32'h1 << (6 - ch));
            for (int a = 1; a < 4; a++) begin
                t = m_cnt + 40;
                wr(ch == 3 ? 12'h010 : 12'(24 + 4 * ch), t);
                wr(12'h02c, a << (6 - 2 * ch));
                wait_cnt(t + 1);
                chk(flg[6 - ch] === 1'b1 && pin[3 - ch] === exp_pin[ch] && irq === 1'b1, "match");
                exp_pin[ch] = (a == 1) ? ~exp_pin[ch] : a[0];
                wait_cnt(t + 2);
                chk(pin[3 - ch] === exp_pin[ch] && oe_n[3 - ch] === 1'b0, "pin action");
            end
            wr(12'h030, 32'h0);
            rchk(12'h030, 16'h1 << (6 - ch), 16'h1 << (6 - ch), "flag kept");
        end
        wr(12'h02c, 32'h0);
        d = 8'($random(seed));
        m = 8'($random(seed)) | 8'h08;
        wr(12'h024, {24'h0, m & 8'hf8});
        wr(12'h028, {24'h0, d});
        t = m_cnt + 40;
        wr(12'h014, t);
        wait_cnt(t + 2);
        chk(pin === (({1'b0, exp_pin[0], exp_pin[1], exp_pin[2], exp_pin[3]} & ~m[7:3]) | (d[7:3] & m[7:3])),
            "channel one");
        finish_test;
    end
endmodule
